// File: hw/spdm_port.sv
// Six-bit port top: AHB-Lite register slave, pin synchroniser and registered pin drive.
// Assumes one AHB-Lite master, DMA strobes and mode from logic on the same clock.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module spdm_port
    import spdm_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [DATA_W-1:0]   haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [DATA_W-1:0]   hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic      [DATA_W-1:0]   hrdata,
    // Chip mode
    input  wire logic [MODE_W-1:0]   op_mode,
    // DMA controllers
    input  wire spdm_dma_ctrl_type   dma_ctrl,
    input  wire spdm_dma_strobe_type dma_strobe,
    // Port pins
    input  wire logic [PORT_W-1:0]   pin_in,
    output logic      [PORT_W-1:0]   pin_out,
    output logic      [PORT_W-1:0]   pin_oe
);

    function automatic logic spdm_hit(input logic [DATA_W-1:0] addr,
                                      input logic [DATA_W-1:0] offset);
        spdm_hit = (addr == offset);
    endfunction

    spdm_bus_state_type     state_reg;
    spdm_bus_state_type     state_next;
    logic [DATA_W-1:0]      addr_reg;
    logic [DATA_W-1:0]      hrdata_reg;
    logic [PORT_W-1:0]      latch_reg;
    logic [PORT_W-1:0]      dir_reg;
    logic [CTRL_W-1:0]      ctrl_reg;
    logic [PORT_W-1:0]      pin_meta_reg;
    logic [PORT_W-1:0]      pin_sync_reg;
    logic [PORT_W-1:0]      pin_out_reg;
    logic [PORT_W-1:0]      pin_oe_reg;

    wire logic              take;
    wire logic              write_en;
    wire logic              hit_latch;
    wire logic              hit_view;
    wire logic              hit_dir;
    wire logic              hit_ctrl;
    wire logic              group_sel;
    wire logic              expand_en;
    wire logic              narrow_mode;
    wire logic              ext_allowed;
    wire logic [PORT_W-1:0] view;
    wire logic [PORT_W-1:0] pin_out_next;
    wire logic [PORT_W-1:0] pin_oe_next;
    wire logic [PORT_W-1:0] claimed;
    wire logic [DATA_W-1:0] rd_mux;

    // Bus address phase and data-phase decode.
    assign take      = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    assign write_en  = (state_reg == BUS_WRITE);
    assign hit_latch = spdm_hit(addr_reg, ADDR_LATCH);
    assign hit_view  = spdm_hit(addr_reg, ADDR_VIEW);
    assign hit_dir   = spdm_hit(addr_reg, ADDR_DIR);
    assign hit_ctrl  = spdm_hit(addr_reg, ADDR_CTRL);

    always_comb begin
        state_next = BUS_IDLE;
        unique case (state_reg)
            BUS_RDWAIT: state_next = BUS_RDDONE;
            BUS_IDLE, BUS_WRITE, BUS_RDDONE: begin
                if (take) begin
                    state_next = hwrite ? BUS_WRITE : BUS_RDWAIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= BUS_IDLE;
            addr_reg  <= ADDR_LATCH;
        end else begin
            state_reg <= state_next;
            if (take) begin
                addr_reg <= haddr;
            end
        end
    end

    // Register file; the pin-state view has no storage and ignores writes.
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_reg <= LATCH_RST;
            dir_reg   <= DIR_RST;
            ctrl_reg  <= CTRL_RST;
        end else if (write_en) begin
            if (hit_latch) begin
                latch_reg <= hwdata[PORT_W-1:0];
            end
            if (hit_dir) begin
                dir_reg <= hwdata[PORT_W-1:0];
            end
            if (hit_ctrl) begin
                ctrl_reg <= hwdata[CTRL_W-1:0];
            end
        end
    end

    // Pin levels pass two flip-flops before anything reads them.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= LATCH_RST;
            pin_sync_reg <= LATCH_RST;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign view = (dir_reg & latch_reg) | (~dir_reg & pin_sync_reg);

    // Direction reads back as zero; reserved upper bits read as zero.
    assign rd_mux = hit_latch ? {{(DATA_W-PORT_W){1'b0}}, latch_reg} :
                    hit_view  ? {{(DATA_W-PORT_W){1'b0}}, view}      :
                    hit_ctrl  ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg}  :
                                {DATA_W{1'b0}};

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_reg <= {DATA_W{1'b0}};
        end else if (state_reg == BUS_RDWAIT) begin
            hrdata_reg <= rd_mux;
        end
    end

    assign hreadyout = (state_reg != BUS_RDWAIT);
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_reg;

    // Pin-function selection.
    assign group_sel   = ctrl_reg[CTRL_GROUP_BIT];
    assign expand_en   = ctrl_reg[CTRL_EXPAND_BIT];
    assign narrow_mode = (op_mode == MODE_NARROW_A) | (op_mode == MODE_NARROW_B);
    assign ext_allowed = ~(narrow_mode & ~expand_en);

    spdm_pin_mux u_pin_mux (
        .group_sel    (group_sel),
        .ext_allowed  (ext_allowed),
        .dma_ctrl     (dma_ctrl),
        .dma_strobe   (dma_strobe),
        .dir          (dir_reg),
        .latch        (latch_reg),
        .pin_out_next (pin_out_next),
        .pin_oe_next  (pin_oe_next),
        .claimed      (claimed)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_reg <= LATCH_RST;
            pin_oe_reg  <= DIR_RST;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    assign pin_out = pin_out_reg;
    assign pin_oe  = pin_oe_reg;

    // Checks on the register file, bus wait states, pin synchroniser and pin reset.
    AST_LATCH_WRITE: assert property (@(posedge clk) disable iff (rst)
        (write_en && hit_latch) |=> (latch_reg == $past(hwdata[PORT_W-1:0])))
        else $error("Latch did not take the written value.");

    AST_LATCH_RESERVED: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDDONE && hit_latch) |-> (hrdata[DATA_W-1:PORT_W] == '0))
        else $error("Reserved latch bits did not read as zero.");

    AST_VIEW_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
        (write_en && hit_view) |=> ($stable(latch_reg) && $stable(dir_reg) && $stable(ctrl_reg)))
        else $error("Write to the pin-state view changed a register.");

    AST_VIEW_OUTPUT_BIT: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDWAIT && hit_view && dir_reg[0])
        |=> (hrdata[0] == $past(latch_reg[0])))
        else $error("Pin-state read of an output pin did not return the latch.");

    AST_VIEW_INPUT_BIT: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDWAIT && hit_view && !dir_reg[1])
        |=> (hrdata[1] == $past(pin_in[1], 3)))
        else $error("Pin-state read of an input pin did not return the pin level.");

    AST_DIR_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDDONE && hit_dir) |-> (hrdata == '0))
        else $error("Direction register read was not zero.");

    AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst)
        ##2 (pin_sync_reg == $past(pin_in, 2)))
        else $error("Pin synchroniser delay is not two cycles.");

    AST_READ_WAIT: assert property (@(posedge clk) disable iff (rst)
        (take && !hwrite) |=> (!hreadyout ##1 hreadyout))
        else $error("Read answer did not take exactly one wait state.");

    AST_REG_RESET: assert property (@(posedge clk)
        rst |=> (latch_reg == LATCH_RST && dir_reg == DIR_RST && ctrl_reg == CTRL_RST))
        else $error("Registers did not clear at reset.");

    AST_PIN_RESET: assert property (@(posedge clk)
        rst |=> (pin_oe == DIR_RST && pin_out == LATCH_RST))
        else $error("Pins were driven out of reset.");

    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
        !(write_en && hit_latch) |=> $stable(latch_reg))
        else $error("Latch changed without a write.");

    AST_LATCH_READ: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDWAIT && hit_latch) |=> (hrdata[PORT_W-1:0] == $past(latch_reg)))
        else $error("Latch read did not return the latch.");

    AST_DIR_WRITE: assert property (@(posedge clk) disable iff (rst)
        (write_en && hit_dir) |=> (dir_reg == $past(hwdata[PORT_W-1:0])))
        else $error("Direction did not take the written value.");

    AST_DIR_HOLD: assert property (@(posedge clk) disable iff (rst)
        !(write_en && hit_dir) |=> $stable(dir_reg))
        else $error("Direction changed without a write.");

    AST_VIEW_RESERVED: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDDONE && hit_view) |-> (hrdata[DATA_W-1:PORT_W] == '0))
        else $error("Reserved pin-state bits did not read as zero.");

    AST_VIEW_OUTPUT_TOP: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDWAIT && hit_view && dir_reg[5])
        |=> (hrdata[5] == $past(latch_reg[5])))
        else $error("Pin-state read of output pin 5 did not return the latch.");

    AST_VIEW_INPUT_TOP: assert property (@(posedge clk) disable iff (rst)
        (state_reg == BUS_RDWAIT && hit_view && !dir_reg[5])
        |=> (hrdata[5] == $past(pin_in[5], 3)))
        else $error("Pin-state read of input pin 5 did not return the level.");

    AST_WRITE_NO_WAIT: assert property (@(posedge clk) disable iff (rst)
        (take && hwrite) |=> hreadyout)
        else $error("Write data phase inserted a wait state.");

    AST_HRDATA_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state_reg != BUS_RDWAIT) |=> $stable(hrdata))
        else $error("Read data changed outside a read.");

    // Checks on the pin multiplexer, with owner requests worked out again per channel.
    wire logic [CH_N-1:0] ext_ack_req;
    wire logic [CH_N-1:0] ext_end_req;
    wire logic [CH_N-1:0] chip_ack_req;
    wire logic [CH_N-1:0] chip_end_req;

    assign ext_ack_req  = {CH_N{ext_allowed}} & dma_ctrl.ext_addr_mode;
    assign ext_end_req  = {CH_N{ext_allowed}} & dma_ctrl.ext_end_enable;
    assign chip_ack_req = {CH_N{group_sel}} & dma_ctrl.single_addr_enable;
    assign chip_end_req = {CH_N{group_sel}} & dma_ctrl.end_out_enable;
    AST_GPIO_DRIVE: assert property (@(posedge clk) disable iff (rst)
        dir_reg[0] |=> (pin_oe[0] && pin_out[0] == $past(latch_reg[0])))
        else $error("General-purpose output did not drive the latch value.");

    AST_GPIO_INPUT: assert property (@(posedge clk) disable iff (rst)
        (!dir_reg[1] && !claimed[1]) |=> !pin_oe[1])
        else $error("General-purpose input pin was driven.");

    AST_DIR_OUTPUT: assert property (@(posedge clk) disable iff (rst)
        (dir_reg[3] && !claimed[3]) |=> (pin_oe[3] && pin_out[3] == $past(latch_reg[3])))
        else $error("Direction bit set did not make the pin an output.");

    AST_ACK5_EXT: assert property (@(posedge clk) disable iff (rst)
        ext_ack_req[1]
        |=> (pin_oe[5] && pin_out[5] == $past(dma_strobe.ext_acknowledge[1])))
        else $error("Pin 5 did not carry the external acknowledge.");

    AST_ACK5_ONCHIP: assert property (@(posedge clk) disable iff (rst)
        (!ext_ack_req[1] && chip_ack_req[1])
        |=> (pin_oe[5] && pin_out[5] == $past(dma_strobe.acknowledge[1])))
        else $error("Pin 5 did not carry the on-chip acknowledge.");

    AST_ACK4_EXT: assert property (@(posedge clk) disable iff (rst)
        ext_ack_req[0]
        |=> (pin_oe[4] && pin_out[4] == $past(dma_strobe.ext_acknowledge[0])))
        else $error("Pin 4 did not carry the external acknowledge.");

    AST_ACK4_ONCHIP: assert property (@(posedge clk) disable iff (rst)
        (!ext_ack_req[0] && chip_ack_req[0])
        |=> (pin_oe[4] && pin_out[4] == $past(dma_strobe.acknowledge[0])))
        else $error("Pin 4 did not carry the on-chip acknowledge.");

    AST_END3_EXT: assert property (@(posedge clk) disable iff (rst)
        ext_end_req[1]
        |=> (pin_oe[3] && pin_out[3] == $past(dma_strobe.ext_transfer_end[1])))
        else $error("Pin 3 did not carry the external end strobe.");

    AST_END3_ONCHIP: assert property (@(posedge clk) disable iff (rst)
        (!ext_end_req[1] && chip_end_req[1])
        |=> (pin_oe[3] && pin_out[3] == $past(dma_strobe.transfer_end[1])))
        else $error("Pin 3 did not carry the on-chip end.");

    AST_END2_EXT: assert property (@(posedge clk) disable iff (rst)
        ext_end_req[0]
        |=> (pin_oe[2] && pin_out[2] == $past(dma_strobe.ext_transfer_end[0])))
        else $error("Pin 2 did not carry the external end strobe.");

    AST_END2_ONCHIP: assert property (@(posedge clk) disable iff (rst)
        (!ext_end_req[0] && chip_end_req[0])
        |=> (pin_oe[2] && pin_out[2] == $past(dma_strobe.transfer_end[0])))
        else $error("Pin 2 did not carry the on-chip end.");

    AST_NO_GROUP_GPIO: assert property (@(posedge clk) disable iff (rst)
        (!ext_ack_req[0] && !group_sel && !dir_reg[4]) |=> !pin_oe[4])
        else $error("On-chip enable claimed a pin without the group select.");

    AST_UNCLAIMED_OUT: assert property (@(posedge clk) disable iff (rst)
        (!claimed[4] && dir_reg[4]) |=> (pin_oe[4] && pin_out[4] == $past(latch_reg[4])))
        else $error("Unclaimed output pin did not drive the latch.");

    AST_CLAIMED_KEEPS: assert property (@(posedge clk) disable iff (rst)
        (claimed[5] && !(write_en && hit_latch)) |=> $stable(latch_reg))
        else $error("Latch changed while a pin was claimed.");

    AST_EXT_BLOCKED_END: assert property (@(posedge clk) disable iff (rst)
        (narrow_mode && !expand_en && !chip_end_req[0] && !dir_reg[2]) |=> !pin_oe[2])
        else $error("External end select claimed a pin in a narrow mode.");

    AST_EXT_BLOCKED: assert property (@(posedge clk) disable iff (rst)
        (narrow_mode && !expand_en && !group_sel && !dir_reg[5]) |=> !pin_oe[5])
        else $error("External select claimed a pin in a narrow mode.");

    AST_SWITCH_NEXT: assert property (@(posedge clk) disable iff (rst)
        $changed(claimed) |=> (pin_oe == $past(claimed | dir_reg)))
        else $error("Pin owner did not switch on the following clock.");

endmodule // spdm_port

`default_nettype wire

// File: hw/spdm_pkg.sv
// Constants, register map and carrier types of the six-bit port with its DMA pin multiplexer.
// Assumes an AHB-Lite system bus, a 25 MHz system clock and a synchronous active-high reset.
// Function
// - Output latch holds bits 5 to 0, cleared at reset, software read and write.
// - Latch drives a pin only while that pin is general-purpose I/O.
// - Latch bits 7 and 6 read as zero and ignore writes.
// - Pin-state view is read only; writes to it change nothing.
// - Pin-state read returns the latch bit where the direction bit is one.
// - Pin-state read returns the sampled pin level where the direction bit is zero.
// - Pin-state bits 7 and 6 are reserved; software must not rely on them.
// - Pin 5 carries external channel 1 acknowledge, else on-chip channel 1 acknowledge.
// - Pin 4 carries external channel 0 acknowledge, else on-chip channel 0 acknowledge.
// - Pin 3 carries external channel 1 end strobe, else on-chip channel 1 end.
// - Pin 2 carries external channel 0 end strobe, else on-chip channel 0 end.
// - Unclaimed pins are general-purpose I/O steered by their direction bits.
// - External DMA selects are ignored in modes 3 and 7 without bus expansion.
// - Direction bit one makes a general-purpose pin an output, zero an input.
// - Direction register is write only; its read value is not defined. This port reads it back as zero.

`default_nettype none

package spdm_pkg;

    localparam int PORT_W   = 6;
    localparam int DATA_W   = 32;
    localparam int MODE_W   = 3;
    localparam int CH_N     = 2;
    localparam int CTRL_W   = 2;

    localparam int ACK_PIN_BASE = 4;
    localparam int END_PIN_BASE = 2;

    localparam logic [DATA_W-1:0] ADDR_LATCH    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ADDR_VIEW     = 32'h0000_0004;
    localparam logic [DATA_W-1:0] ADDR_DIR      = 32'h0000_0008;
    localparam logic [DATA_W-1:0] ADDR_CTRL     = 32'h0000_000c;

    localparam logic [PORT_W-1:0] LATCH_RST = 6'h00;
    localparam logic [PORT_W-1:0] DIR_RST   = 6'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST  = 2'h0;

    localparam int CTRL_GROUP_BIT  = 0;
    localparam int CTRL_EXPAND_BIT = 1;

    localparam logic [MODE_W-1:0] MODE_NARROW_A = 3'h3;
    localparam logic [MODE_W-1:0] MODE_NARROW_B = 3'h7;

    localparam int   HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY        = 1'b0;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_WRITE  = 2'b01,
        BUS_RDWAIT = 2'b10,
        BUS_RDDONE = 2'b11
    } spdm_bus_state_type;

    typedef struct packed {
        logic [CH_N-1:0] ext_addr_mode;
        logic [CH_N-1:0] ext_end_enable;
        logic [CH_N-1:0] single_addr_enable;
        logic [CH_N-1:0] end_out_enable;
    } spdm_dma_ctrl_type;

    typedef struct packed {
        logic [CH_N-1:0] ext_acknowledge;
        logic [CH_N-1:0] ext_transfer_end;
        logic [CH_N-1:0] acknowledge;
        logic [CH_N-1:0] transfer_end;
    } spdm_dma_strobe_type;

endpackage

`default_nettype wire

// File: hw/spdm_pin_mux.sv
// Combinational owner selection for the six port pins.
// Assumes control bits and DMA strobes arrive from logic on the system clock.
`timescale 1ns/1ns
`default_nettype none

module spdm_pin_mux
    import spdm_pkg::*;
(
    // Pin-function controls
    input  wire logic                group_sel,
    input  wire logic                ext_allowed,
    input  wire spdm_dma_ctrl_type   dma_ctrl,
    input  wire spdm_dma_strobe_type dma_strobe,
    // General-purpose settings
    input  wire logic [PORT_W-1:0]   dir,
    input  wire logic [PORT_W-1:0]   latch,
    // Pin drive
    output logic      [PORT_W-1:0]   pin_out_next,
    output logic      [PORT_W-1:0]   pin_oe_next,
    output logic      [PORT_W-1:0]   claimed
);

    wire logic [PORT_W-1:0] claim_w;
    wire logic [PORT_W-1:0] func_w;

    genvar ch;
    generate
        for (ch = 0; ch < CH_N; ch++) begin : g_channel
            wire logic ext_ack = ext_allowed & dma_ctrl.ext_addr_mode[ch];
            wire logic int_ack = dma_ctrl.single_addr_enable[ch] & group_sel;
            wire logic ext_end = ext_allowed & dma_ctrl.ext_end_enable[ch];
            wire logic int_end = dma_ctrl.end_out_enable[ch] & group_sel;
            assign claim_w[ACK_PIN_BASE+ch] = ext_ack | int_ack;
            assign func_w[ACK_PIN_BASE+ch]  = ext_ack ? dma_strobe.ext_acknowledge[ch]
                                            : dma_strobe.acknowledge[ch];
            assign claim_w[END_PIN_BASE+ch] = ext_end | int_end;
            assign func_w[END_PIN_BASE+ch]  = ext_end ? dma_strobe.ext_transfer_end[ch]
                                            : dma_strobe.transfer_end[ch];
        end
        for (ch = 0; ch < END_PIN_BASE; ch++) begin : g_plain
            assign claim_w[ch] = 1'b0;
            assign func_w[ch]  = 1'b0;
        end
    endgenerate

    assign claimed      = claim_w;
    assign pin_out_next = (claim_w & func_w) | (~claim_w & latch);
    assign pin_oe_next  = claim_w | dir;

endmodule // spdm_pin_mux

`default_nettype wire

// File: testbench/spdm_far_model.sv
// Far side of the port pins: resolves each pin wire from the port drive and the outside level.
// Assumes the bench supplies the level that outside logic puts on undriven pins.
`timescale 1ns/1ns
`default_nettype none

module spdm_far_model
    import spdm_pkg::*;
(
    // Port drive
    input  wire logic [PORT_W-1:0] pin_out,
    input  wire logic [PORT_W-1:0] pin_oe,
    // Outside level
    input  wire logic [PORT_W-1:0] ext_level,
    // Resolved wire
    output logic      [PORT_W-1:0] pin_in
);
    // A driven pin shows the port value, an undriven one the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // spdm_far_model

`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the six-bit port: register access, pin view and pin ownership.
// Assumes the port and the far-side pin model; one AHB-Lite master, one slave.
`timescale 1ns/1ns
`default_nettype none

module tb;
    import spdm_pkg::*;

    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                hsel = 1'b0;
    logic [DATA_W-1:0]   haddr = '0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [DATA_W-1:0]   hwdata = '0;
    logic                hreadyout;
    logic                hresp;
    logic [DATA_W-1:0]   hrdata;
    logic [MODE_W-1:0]   op_mode = 3'h1;
    spdm_dma_ctrl_type   dma_ctrl = '0;
    spdm_dma_strobe_type dma_strobe = '0;
    logic [PORT_W-1:0]   pin_in;
    logic [PORT_W-1:0]   pin_out;
    logic [PORT_W-1:0]   pin_oe;
    logic [PORT_W-1:0]   ext_level = 6'h00;
    logic [DATA_W-1:0]   rd;
    int                  err_count = 0;
    int                  checks_done = 0;

    always #20 clk = ~clk;

    spdm_port dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_mode(op_mode),
        .dma_ctrl(dma_ctrl), .dma_strobe(dma_strobe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));

    spdm_far_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));

    task automatic results;
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: bus wait ran out", $time);
            results();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    endtask

    task automatic t_reset;
        bus(1'b0, ADDR_LATCH, 0);
        check(rd, 32'h0, "latch reset");
        check({26'h0, pin_oe}, 32'h0, "oe reset");
    endtask

    task automatic t_latch;
        bus(1'b1, ADDR_LATCH, 32'hffff_ffd2);
        bus(1'b0, ADDR_LATCH, 0);
        check(rd, 32'h12, "latch bits");
        bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
        bus(1'b0, 32'h0000_0010, 0);
        check(rd, 32'h0, "unmapped read");
        bus(1'b1, ADDR_VIEW, 32'h0000_003f);
        bus(1'b0, ADDR_LATCH, 0);
        check(rd, 32'h12, "view write leaves latch");
    endtask

    task automatic t_view;
        bus(1'b1, ADDR_DIR, 0);
        @(posedge clk);
        ext_level <= 6'h2d;
        repeat (4) @(posedge clk);
        bus(1'b0, ADDR_VIEW, 0);
        check(rd & 32'h3f, 32'h2d, "input view");
        bus(1'b1, ADDR_VIEW, 32'h0000_0000);
        bus(1'b0, ADDR_VIEW, 0);
        check(rd & 32'h3f, 32'h2d, "view after write");
        bus(1'b1, ADDR_LATCH, 32'h2a);
        bus(1'b1, ADDR_DIR, 32'h3f);
        bus(1'b0, ADDR_DIR, 0);
        check(rd, 32'h0, "direction read");
        @(posedge clk);
        dma_ctrl   <= '{ext_addr_mode: 2'b10, ext_end_enable: 2'b00,
                        single_addr_enable: 2'b00, end_out_enable: 2'b00};
        dma_strobe <= '0;
        repeat (4) @(posedge clk);
        #1;
        check({26'h0, pin_out}, 32'h0a, "acknowledge over latch");
        bus(1'b0, ADDR_VIEW, 0);
        check(rd & 32'h3f, 32'h2a, "output view");
    endtask

    task automatic t_mux;
        logic [7:0]          pat [5];
        spdm_dma_ctrl_type   ctl;
        spdm_dma_strobe_type stb;
        logic [3:0]          xs;
        logic [3:0]          os;
        logic [3:0]          o4;
        logic [5:0]          eoe;
        logic                ok;
        pat = '{8'hff, 8'h00, 8'ha5, 8'h5a, 8'hc3};
        bus(1'b1, ADDR_DIR, 32'h0f);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, ADDR_CTRL, c);
            bus(1'b0, ADDR_CTRL, 0);
            check(rd, c, "control read");
            for (int m = 0; m < 8; m++) begin
                for (int k = 0; k < 5; k++) begin
                    ctl = pat[k];
                    stb = ~pat[k] ^ 8'(m);
                    @(posedge clk);
                    op_mode    <= m[2:0];
                    dma_ctrl   <= ctl;
                    dma_strobe <= stb;
                    @(posedge clk);
                    #1;
                    ok  = !((m == 3 || m == 7) && c[1] == 1'b0);
                    xs  = {ctl.ext_addr_mode, ctl.ext_end_enable} & {4{ok}};
                    os  = {ctl.single_addr_enable, ctl.end_out_enable} & {4{c[0]}};
                    o4  = (xs & {stb.ext_acknowledge, stb.ext_transfer_end})
                        | (~xs & os & {stb.acknowledge, stb.transfer_end})
                        | (~xs & ~os & 4'ha);
                    eoe = {xs | os | 4'h3, 2'h3};
                    check({26'h0, pin_oe}, {26'h0, eoe}, "pin owner");
                    check({26'h0, pin_out & eoe}, {26'h0, {o4, 2'h2} & eoe},
                        "pin value");
                end
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_latch();
        t_view();
        t_mux();
        results();
    end
endmodule // tb

`default_nettype wire
